// file: core/isf_pkg.sv
// Constants, register map and shared types for the interrupt status
// and bus-fault cause block.
// Assumes one 20 MHz clock domain and an APB register bus with 32-bit data.
package isf_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ISF_ADDR_ACTIVE = 32'he000e300;
    localparam logic [31:0] ISF_ADDR_MISSED = 32'h4000a820;
    localparam logic [31:0] ISF_ADDR_FAULT = 32'he000ed3c;
    localparam logic [31:0] ISF_ADDR_ISTAT = 32'h4000a824;
    localparam logic [31:0] ISF_ADDR_IMASK = 32'h4000a828;

    // ------------------------------------------------------------------
    // Widths, field positions and reset values
    // ------------------------------------------------------------------
    localparam int ISF_NSRC = 17;
    localparam int ISF_DEBUG_BIT = 16;
    localparam int ISF_MISS_HI = 15;
    localparam int ISF_MISS_LO = 2;
    localparam int ISF_NFAULT = 4;
    localparam int ISF_F_WRONG_SIZE = 3;
    localparam int ISF_F_PROTECT = 2;
    localparam int ISF_F_UNIMPL = 1;
    localparam int ISF_F_OVERFLOW = 0;
    localparam int ISF_NEVT = 2;
    localparam int ISF_EVT_MISS = 0;
    localparam int ISF_EVT_FAULT = 1;
    localparam logic [16:0] ISF_ACTIVE_RST = 17'h00000;
    localparam logic [15:0] ISF_MISSED_RST = 16'h0000;
    localparam logic [15:0] ISF_MISSED_IMPL = 16'hfffc;
    localparam logic [3:0] ISF_FAULT_RST = 4'h0;
    localparam logic [1:0] ISF_EVT_RST = 2'h0;
    localparam logic [31:0] ISF_RDATA_RST = 32'h00000000;
    localparam logic [1:0] ISF_WORD_ALIGNED = 2'h0;

    // Register selected by a bus address.
    typedef enum logic [2:0] {
        ISF_REG_NONE,
        ISF_REG_ACTIVE,
        ISF_REG_MISSED,
        ISF_REG_FAULT,
        ISF_REG_ISTAT,
        ISF_REG_IMASK
    } isf_reg_t;

    // Size of the faulting bus access.
    typedef enum logic [1:0] {
        ISF_SIZE_BYTE = 2'h0,
        ISF_SIZE_HALF = 2'h1,
        ISF_SIZE_WORD = 2'h2
    } isf_size_t;

endpackage : isf_pkg

// file: core/isf_miss_flags.sv
// Missed-interrupt flags, one per source from external line D down to
// management; the lowest two bits do not exist and read zero.
// Assumes source lines and pending flags synchronous to clk.
`timescale 1ns/1ps
module isf_miss_flags (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Source lines and their pending state.
    input wire logic [isf_pkg::ISF_NSRC-1:0] src_line,
    input wire logic [isf_pkg::ISF_NSRC-1:0] src_pending,
    // Write-one-to-clear request from the register bus.
    input wire logic [15:0] clr,
    // Flags and a pulse whenever a miss is seen, even on a flag already set.
    output logic [15:0] flags,
    output logic set_evt
);
    import isf_pkg::*;

    typedef struct packed {
        logic [ISF_NSRC-1:0] prev;
        logic [15:0] flags;
    } isf_miss_state_t;

    isf_miss_state_t cur_ff;
    isf_miss_state_t nxt_st;
    logic [15:0] hits;

    // A new assertion of a line whose interrupt is still pending is a miss;
    // setting wins over a clear that arrives in the same cycle.
    always_comb begin
        nxt_st = cur_ff;
        hits = (src_line[15:0] & ~cur_ff.prev[15:0] & src_pending[15:0])
            & ISF_MISSED_IMPL; // (R12)
        set_evt = ce && (hits != 16'h0000);
        if (ce) begin
            nxt_st.prev = src_line;
            nxt_st.flags = ((cur_ff.flags & ~clr) | hits) & ISF_MISSED_IMPL; // (R3)
        end
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff <= '0; // (R4)
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign flags = cur_ff.flags;

endmodule : isf_miss_flags

// file: core/isf_fault_cause.sv
// Bus-fault cause flags: wrong size, protection, unimplemented address
// and overflow. The fault source reports one classified fault per pulse.
// Assumes all fault inputs valid in the cycle of fault_valid.
`timescale 1ns/1ps
module isf_fault_cause (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Fault report.
    input wire logic fault_valid,
    input wire isf_pkg::isf_size_t fault_size,
    input wire logic [1:0] fault_addr_lo,
    input wire logic fault_write,
    input wire logic fault_privileged,
    input wire logic fault_periph_reg,
    input wire logic fault_protected_target,
    input wire logic fault_beyond_block,
    input wire logic fault_beyond_memory,
    // Write-one-to-clear request from the register bus.
    input wire logic [isf_pkg::ISF_NFAULT-1:0] clr,
    // Flags and a pulse for each recorded fault.
    output logic [isf_pkg::ISF_NFAULT-1:0] flags,
    output logic set_evt
);
    import isf_pkg::*;

    typedef struct packed {
        logic [ISF_NFAULT-1:0] flags;
    } isf_fault_state_t;

    isf_fault_state_t cur_ff;
    isf_fault_state_t nxt_st;
    logic [ISF_NFAULT-1:0] hits;

    // Classify the fault; overflow looks at the flags held before this fault.
    always_comb begin
        nxt_st = cur_ff;
        hits = '0;
        hits[ISF_F_WRONG_SIZE] = (fault_periph_reg && fault_size != ISF_SIZE_WORD) // (R5)
            || (fault_size == ISF_SIZE_WORD && fault_addr_lo != ISF_WORD_ALIGNED); // (R6)
        hits[ISF_F_PROTECT] = fault_write && !fault_privileged
            && fault_protected_target; // (R7)
        hits[ISF_F_UNIMPL] = fault_beyond_block // (R8)
            || fault_beyond_memory; // (R9)
        hits[ISF_F_OVERFLOW] = (cur_ff.flags != ISF_FAULT_RST); // (R10)
        set_evt = ce && fault_valid;
        if (ce) begin
            nxt_st.flags = (cur_ff.flags & ~clr) | (fault_valid ? hits : '0); // (R11)
        end
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff <= '0; // (R11)
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign flags = cur_ff.flags;

endmodule : isf_fault_cause

// file: core/isf_top.sv
// Top of the interrupt status and bus-fault cause block: APB slave,
// active-interrupt flags, missed flags, fault causes and one interrupt.
// Assumes a single clock, synchronous inputs and an APB master.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// (R1) One read-only active flag per source, debug at bit 16, timer 1 at bit 0.
// (R2) Active register resets to zero; bits 31 to 17 read zero.
// (R3) Missed flags exist for bits 15 to 2 only; bits 1 and 0 read zero.
// (R4) Missed flags are software accessible, reset to zero, bits 31 to 16 read zero.
// (R5) Byte or halfword access to a peripheral register sets the wrong-size flag.
// (R6) An unaligned word access also sets the wrong-size flag.
// (R7) Unprivileged write to a protected target sets the protection flag.
// (R8) Access above the last register of a peripheral block sets the unimplemented flag.
// (R9) Access above top of RAM or flash also sets the unimplemented flag.
// (R10) A fault while any cause flag is set sets the overflow flag.
// (R11) Fault cause register resets to zero, four flags accessible, upper bits zero.
// (R12) A new source assertion while still pending sets its missed flag; write one clears.
// (R13) Active flag holds from handler entry until that handler returns.
module isf_top (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt source lines and their pending state.
    input wire logic [isf_pkg::ISF_NSRC-1:0] src_line,
    input wire logic [isf_pkg::ISF_NSRC-1:0] src_pending,
    // Handler entry and return from the processor core.
    input wire logic hdl_enter,
    input wire logic [4:0] hdl_enter_num,
    input wire logic hdl_return,
    input wire logic [4:0] hdl_return_num,
    // Bus-fault report.
    input wire logic fault_valid,
    input wire isf_pkg::isf_size_t fault_size,
    input wire logic [1:0] fault_addr_lo,
    input wire logic fault_write,
    input wire logic fault_privileged,
    input wire logic fault_periph_reg,
    input wire logic fault_protected_target,
    input wire logic fault_beyond_block,
    input wire logic fault_beyond_memory,
    // Interrupt to the core.
    output logic irq
);
    import isf_pkg::*;

    // ------------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------------

    typedef struct packed {
        logic [ISF_NSRC-1:0] active;
        logic [ISF_NEVT-1:0] istat;
        logic [ISF_NEVT-1:0] imask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } isf_top_state_t;

    isf_top_state_t cur_ff;
    isf_top_state_t nxt_st;

    logic [15:0] miss_flags;
    logic [ISF_NFAULT-1:0] fault_flags;
    logic miss_evt;
    logic fault_evt;
    logic wr_done;
    isf_reg_t wr_sel;
    logic [31:0] wr_ones;
    logic [31:0] wr_lanes;
    logic [15:0] miss_clr;
    logic [ISF_NFAULT-1:0] fault_clr;

    // Maps a full byte address onto the register it selects.
    function automatic isf_reg_t isf_decode(input logic [31:0] addr);
        isf_reg_t sel;
        sel = ISF_REG_NONE;
        unique case (addr)
            ISF_ADDR_ACTIVE: sel = ISF_REG_ACTIVE;
            ISF_ADDR_MISSED: sel = ISF_REG_MISSED;
            ISF_ADDR_FAULT: sel = ISF_REG_FAULT;
            ISF_ADDR_ISTAT: sel = ISF_REG_ISTAT;
            ISF_ADDR_IMASK: sel = ISF_REG_IMASK;
            default: sel = ISF_REG_NONE;
        endcase
        return sel;
    endfunction : isf_decode

    // Expands byte strobes to a bit mask so partial writes touch only
    // the lanes the master enabled.
    function automatic logic [31:0] isf_lanes(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : isf_lanes

    // One-hot bit for a handler number; numbers beyond the debug source
    // select nothing, so stray exception numbers leave the flags alone.
    function automatic logic [ISF_NSRC-1:0] isf_onehot(input logic [4:0] num);
        logic [ISF_NSRC-1:0] v;
        v = '0;
        if (num <= 5'(ISF_DEBUG_BIT)) begin
            v[num] = 1'b1;
        end
        return v;
    endfunction : isf_onehot

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------

    // A write takes effect only at the edge that completes the access
    // phase, which is the cycle in which this block drives pready high.
    always_comb begin
        wr_done = ce && psel && penable && pwrite && cur_ff.pready;
        wr_sel = isf_decode(paddr);
        wr_lanes = isf_lanes(pstrb);
        wr_ones = pwdata & wr_lanes;
        miss_clr = '0;
        fault_clr = '0;
        if (wr_done && wr_sel == ISF_REG_MISSED) begin
            miss_clr = wr_ones[15:0] & ISF_MISSED_IMPL; // (R12)
        end
        if (wr_done && wr_sel == ISF_REG_FAULT) begin
            fault_clr = wr_ones[ISF_NFAULT-1:0]; // (R11)
        end
    end

    // ------------------------------------------------------------------
    // Flag keepers
    // ------------------------------------------------------------------

    isf_miss_flags u_miss (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .src_line(src_line),
        .src_pending(src_pending),
        .clr(miss_clr),
        .flags(miss_flags),
        .set_evt(miss_evt)
    );

    isf_fault_cause u_fault (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .fault_valid(fault_valid),
        .fault_size(fault_size),
        .fault_addr_lo(fault_addr_lo),
        .fault_write(fault_write),
        .fault_privileged(fault_privileged),
        .fault_periph_reg(fault_periph_reg),
        .fault_protected_target(fault_protected_target),
        .fault_beyond_block(fault_beyond_block),
        .fault_beyond_memory(fault_beyond_memory),
        .clr(fault_clr),
        .flags(fault_flags),
        .set_evt(fault_evt)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Everything holds while ce is low, including a bus access in flight; a setup
    // phase with ce low never raises pready, and a write completing with ce low is lost.
    always_comb begin
        logic [ISF_NEVT-1:0] evt;
        logic [ISF_NEVT-1:0] istat_clr;
        isf_reg_t rd_sel;
        evt = '0;
        istat_clr = '0;
        rd_sel = isf_decode(paddr);
        nxt_st = cur_ff;
        evt[ISF_EVT_MISS] = miss_evt;
        evt[ISF_EVT_FAULT] = fault_evt;
        if (ce) begin
            // Handler entry sets the flag, return clears it; a preempted
            // handler keeps its flag until its own return arrives.
            nxt_st.active = (cur_ff.active
                & ~(hdl_return ? isf_onehot(hdl_return_num) : '0))
                | (hdl_enter ? isf_onehot(hdl_enter_num) : '0); // (R13)

            // Register writes; the active register is read only and
            // silently ignores writes.
            if (wr_done && wr_sel == ISF_REG_ISTAT) begin
                istat_clr = wr_ones[ISF_NEVT-1:0];
            end
            if (wr_done && wr_sel == ISF_REG_IMASK) begin
                nxt_st.imask = wr_ones[ISF_NEVT-1:0]
                    | (cur_ff.imask & ~wr_lanes[ISF_NEVT-1:0]);
            end

            // Sticky events; a new event beats a clear in the same cycle.
            nxt_st.istat = (cur_ff.istat & ~istat_clr) | evt;
            nxt_st.irq = |(nxt_st.istat & nxt_st.imask);

            // APB answer: ready one cycle after the setup phase, dropped
            // once the access completes.
            nxt_st.pready = 1'b0;
            nxt_st.pslverr = 1'b0;
            if (psel && !penable) begin
                nxt_st.pready = 1'b1;
                nxt_st.pslverr = (rd_sel == ISF_REG_NONE);
                nxt_st.prdata = ISF_RDATA_RST;
                if (!pwrite) begin
                    unique case (rd_sel)
                        ISF_REG_ACTIVE: nxt_st.prdata = {15'h0000, cur_ff.active}; // (R1) (R2)
                        ISF_REG_MISSED: nxt_st.prdata = {16'h0000, miss_flags}; // (R4)
                        ISF_REG_FAULT: nxt_st.prdata = {28'h0000000, fault_flags}; // (R11)
                        ISF_REG_ISTAT: nxt_st.prdata = {30'h00000000, cur_ff.istat};
                        ISF_REG_IMASK: nxt_st.prdata = {30'h00000000, cur_ff.imask};
                        ISF_REG_NONE: nxt_st.prdata = ISF_RDATA_RST;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff.active <= ISF_ACTIVE_RST; // (R2)
            cur_ff.istat <= ISF_EVT_RST;
            cur_ff.imask <= ISF_EVT_RST;
            cur_ff.prdata <= ISF_RDATA_RST;
            cur_ff.pready <= 1'b0;
            cur_ff.pslverr <= 1'b0;
            cur_ff.irq <= 1'b0;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops.
    assign prdata = cur_ff.prdata;
    assign pready = cur_ff.pready;
    assign pslverr = cur_ff.pslverr;
    assign irq = cur_ff.irq;

endmodule : isf_top

// file: testbench/isf_top_sva.sv
// Checker for the interrupt status and bus-fault cause block.
// Assumes it is bound into isf_top, with ce high whenever a read is set up.
`timescale 1ns/1ps
module isf_chk (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Sources, handlers and faults.
    input wire logic [16:0] src_line,
    input wire logic [16:0] src_pending,
    input wire logic hdl_enter,
    input wire logic [4:0] hdl_enter_num,
    input wire logic hdl_return,
    input wire logic fault_valid,
    input wire isf_pkg::isf_size_t fault_size,
    input wire logic [1:0] fault_addr_lo,
    input wire logic fault_write,
    input wire logic fault_privileged,
    input wire logic fault_periph_reg,
    input wire logic fault_protected_target,
    input wire logic fault_beyond_block,
    input wire logic fault_beyond_memory
);
    import isf_pkg::*;
    logic [16:0] line_ff;
    logic [15:0] rise;

    // Lines one cycle back, so a rise is seen without nesting sampled functions.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            line_ff <= '0;
        end else if (ce) begin
            line_ff <= src_line;
        end
    end
    assign rise = src_line[15:0] & ~line_ff[15:0] & src_pending[15:0] & ISF_MISSED_IMPL;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence rd(logic [31:0] a);
        psel && !penable && !pwrite && ce && paddr == a;
    endsequence

    chk_active_zero: assert property (rd(ISF_ADDR_ACTIVE) |=> pready && prdata[31:17] == 15'h0)
        else $error("active upper bits not zero");
    chk_missed_zero: assert property (rd(ISF_ADDR_MISSED) |=>
        pready && prdata[31:16] == 16'h0 && prdata[1:0] == 2'h0)
        else $error("missed unused bits not zero");
    chk_fault_zero: assert property (rd(ISF_ADDR_FAULT) |=> pready && prdata[31:4] == 28'h0)
        else $error("fault upper bits not zero");
    chk_size_flag: assert property (fault_valid && ce && (fault_periph_reg &&
        fault_size != ISF_SIZE_WORD || fault_size == ISF_SIZE_WORD && fault_addr_lo != 2'h0)
        ##1 !penable ##1 rd(ISF_ADDR_FAULT) |=> prdata[3]) else $error("size flag missing");
    chk_prot_flag: assert property (fault_valid && ce && fault_write && !fault_privileged &&
        fault_protected_target ##1 !penable ##1 rd(ISF_ADDR_FAULT) |=> prdata[2])
        else $error("protection flag missing");
    chk_unimpl_flag: assert property (fault_valid && ce && (fault_beyond_block ||
        fault_beyond_memory) ##1 !penable ##1 rd(ISF_ADDR_FAULT) |=> prdata[1])
        else $error("unimplemented flag missing");
    chk_ovf_flag: assert property (fault_valid && ce && $past(fault_valid) &&
        $past(fault_beyond_block) ##1 !penable ##1 rd(ISF_ADDR_FAULT) |=> prdata[0])
        else $error("overflow flag missing");
    chk_miss_set: assert property (ce && |rise ##1 !penable ##1 rd(ISF_ADDR_MISSED) |=>
        (prdata[15:0] & $past(rise, 3)) == $past(rise, 3)) else $error("missed flag not set");
    chk_active_set: assert property (hdl_enter && ce && hdl_enter_num <= 5'd16
        ##1 !hdl_return ##1 rd(ISF_ADDR_ACTIVE) |=> prdata[$past(hdl_enter_num, 3)])
        else $error("active flag not set");
endmodule : isf_chk

bind isf_top isf_chk isf_chk_i (.*);

// file: testbench/isf_core_model.sv
// Model of the processor core and the interrupt sources at the far side.
// Assumes the bench calls one task at a time, right after a clock edge.
`timescale 1ns/1ps
module isf_core_model (
    // Clock.
    input wire logic clk,
    // Sources, handlers and faults.
    output logic [16:0] src_line,
    output logic [16:0] src_pending,
    output logic hdl_enter,
    output logic [4:0] hdl_enter_num,
    output logic hdl_return,
    output logic [4:0] hdl_return_num,
    output logic fault_valid,
    // Size, address bits, write, privileged, periph, protected, block, memory.
    output logic [9:0] fault_q
);
    // Idle state at time zero.
    initial begin
        src_line = '0;
        src_pending = '0;
        {hdl_enter, hdl_return, hdl_enter_num, hdl_return_num} = '0;
        fault_valid = 1'b0;
        fault_q = 10'h200;
    end

    // One source fires for one cycle.
    task automatic pulse(input int k, input logic pend);
        @(posedge clk);
        src_line[k] <= 1'b1;
        src_pending[k] <= pend;
        @(posedge clk);
        src_line[k] <= 1'b0;
        src_pending[k] <= 1'b0;
    endtask : pulse

    // Handler entry or return; the number is scrambled once unqualified.
    task automatic hdl(input logic ent, input logic [4:0] n);
        @(posedge clk);
        hdl_enter <= ent;
        hdl_return <= !ent;
        hdl_enter_num <= n;
        hdl_return_num <= n;
        @(posedge clk);
        {hdl_enter, hdl_return} <= 2'h0;
        hdl_enter_num <= ~n;
        hdl_return_num <= ~n;
    endtask : hdl

    // The same fault n cycles in a row; qualifiers then change, size stays legal.
    task automatic report(input logic [9:0] q, input int n);
        repeat (n) begin
            @(posedge clk);
            fault_valid <= 1'b1;
            fault_q <= q;
        end
        @(posedge clk);
        fault_valid <= 1'b0;
        fault_q <= {2'h2, ~q[7:0]};
    endtask : report
endmodule : isf_core_model

// file: testbench/testbench.sv
// Self-checking bench for isf_top with an APB master and the core model.
// Assumes isf_pkg, the core model and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED at %0t: %s", $time, m); end end
module testbench;
    import isf_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, r;
    logic pready, pslverr, irq, e, hdl_enter, hdl_return, fault_valid;
    logic [16:0] src_line, src_pending;
    logic [4:0] hdl_enter_num, hdl_return_num;
    logic [9:0] fq, q;
    logic [3:0] fl;
    int n_errors = 0;
    int cmp_count = 0;
    int nrep;
    int unsigned pend;
    logic [9:0] corner [5] = '{10'h018, 10'h250, 10'h224, 10'h211, 10'h212};

    always #25 clk = ~clk;

    isf_core_model core_i (.clk(clk), .src_line(src_line), .src_pending(src_pending),
        .hdl_enter(hdl_enter), .hdl_enter_num(hdl_enter_num), .hdl_return(hdl_return),
        .hdl_return_num(hdl_return_num), .fault_valid(fault_valid), .fault_q(fq));

    isf_top isf_top_i (.clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_line(src_line), .src_pending(src_pending),
        .hdl_enter(hdl_enter), .hdl_enter_num(hdl_enter_num), .hdl_return(hdl_return),
        .hdl_return_num(hdl_return_num), .fault_valid(fault_valid),
        .fault_size(isf_size_t'(fq[9:8])), .fault_addr_lo(fq[7:6]), .fault_write(fq[5]),
        .fault_privileged(fq[4]), .fault_periph_reg(fq[3]), .fault_protected_target(fq[2]),
        .fault_beyond_block(fq[1]), .fault_beyond_memory(fq[0]), .irq(irq));

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] x, input string m);
        apb(1'b0, a, 32'h0);
        `CHK(r, x, m)
    endtask : rd_chk

    // Cause flags after one more fault; overflow looks at the old flags.
    function automatic logic [3:0] fexp(input logic [3:0] o, input logic [9:0] f);
        logic wsz;
        wsz = (f[3] && f[9:8] != 2'h2) || (f[9:8] == 2'h2 && f[7:6] != 2'h0);
        return o | {wsz, f[5] && !f[4] && f[2], f[1] || f[0], |o};
    endfunction : fexp

    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // About six hundred cycles are needed; twenty thousand means a hang.
    initial begin
        #1000000;
        n_errors++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(87));
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(ISF_ADDR_ACTIVE, 0, "active after reset");
        rd_chk(ISF_ADDR_MISSED, 0, "missed after reset");
        rd_chk(ISF_ADDR_FAULT, 0, "fault after reset");
        apb(1'b1, ISF_ADDR_ACTIVE, 32'hffffffff);
        rd_chk(ISF_ADDR_ACTIVE, 0, "active took a write");
        apb(1'b0, 32'h4000a82c, 32'h0);
        `CHK({e, r}, 33'h100000000, "unmapped answer")
        for (int n = 0; n < 17; n++) begin
            core_i.hdl(1'b1, 5'(n));
            rd_chk(ISF_ADDR_ACTIVE, 32'h1 << n, "active set");
            core_i.hdl(1'b0, 5'(n));
            rd_chk(ISF_ADDR_ACTIVE, 0, "active clear");
        end
        // A rise while pending sets only bits 15 to 2.
        for (int k = 0; k < 17; k++) begin
            pend = $urandom % 2;
            core_i.pulse(k, pend[0]);
            rd_chk(ISF_ADDR_MISSED, pend[0] ? (32'h1 << k) & 32'hfffc : 0, "missed");
            apb(1'b1, ISF_ADDR_MISSED, 32'hffff);
            rd_chk(ISF_ADDR_MISSED, 0, "missed clear");
        end
        // Interrupt raised, masked and cleared; irq updates at the same edge as the status.
        apb(1'b1, ISF_ADDR_ISTAT, 32'h3);
        apb(1'b1, ISF_ADDR_IMASK, 32'h1);
        rd_chk(ISF_ADDR_IMASK, 1, "mask readback");
        core_i.pulse(7, 1'b1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1, "irq not raised")
        apb(1'b1, ISF_ADDR_IMASK, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0, "irq not masked")
        rd_chk(ISF_ADDR_ISTAT, 1, "status not sticky");
        apb(1'b1, ISF_ADDR_ISTAT, 32'h1);
        apb(1'b1, ISF_ADDR_IMASK, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0, "irq not cleared")
        // A source rising while ce is low must leave every flag frozen.
        ce <= 1'b0;
        core_i.pulse(9, 1'b1);
        ce <= 1'b1;
        rd_chk(ISF_ADDR_MISSED, 32'h80, "ce did not freeze flags");
        // Hand-made corner faults first, then random ones, some back to back.
        fl = 4'h0;
        for (int i = 0; i < 24; i++) begin
            q = (i < 5) ? corner[i] : {2'($urandom % 3), 8'($urandom)};
            nrep = (i == 4) ? 2 : ((i < 4) ? 1 : 1 + $urandom % 2);
            core_i.report(q, nrep);
            repeat (nrep) fl = fexp(fl, q);
            rd_chk(ISF_ADDR_FAULT, 32'(fl), "fault flags");
            if (i < 4 || $urandom % 3 == 0) begin
                apb(1'b1, ISF_ADDR_FAULT, 32'hf);
                fl = 4'h0;
            end
        end
        rd_chk(ISF_ADDR_ISTAT, 2, "fault event");
        stop_test();
    end
endmodule : testbench
